// ### src/tdl_buf.sv
// Byte storage of the transmit FIFO with one end-of-message tag per byte.
// Pointers live in the caller; this block only stores and reads by index.
`timescale 1ns/1ps
module tdl_buf
  import tdl_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int DEPTH  = FIFO_DEPTH,
  parameter int AW     = IDX_W
)
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              wr_en,
  input  wire logic [AW-1:0]     wr_idx,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              tag_set,
  input  wire logic [AW-1:0]     tag_idx,
  input  wire logic [AW-1:0]     rd_idx,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_tag,
  output logic                   last_tag
);

  typedef struct packed
  {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [DEPTH-1:0]             tag;
  } tdl_buf_s;

  tdl_buf_s q;
  tdl_buf_s d;

  // ----------------------------------------------------------------
  // Storage update
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    if (wr_en)
    begin
      d.mem[wr_idx] = wr_data;
      d.tag[wr_idx] = 1'b0;
    end
    if (tag_set)
    begin
      d.tag[tag_idx] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rd_data  = q.mem[rd_idx];
  assign rd_tag   = q.tag[rd_idx];
  assign last_tag = q.tag[tag_idx];

endmodule

// ### src/tdl_pkg.sv
// Constants, register map and state codes for the data link transmitter.
// Assumes a single ref_clk domain and the byte-wide processor port.
//
// Summary of operation
// - End-of-message write tags last written byte
// - End-of-message data discarded, reads return zero
// - Several queued HDLC frames sent in order
// - Circular buffer switches only after tagged byte
// - Bytes sent LSB first in selected bits
// - Eight bits sent, six-bit mode sends five..zero
// - In-progress high opening to closing flag
// - In-progress high always in packed modes
// - Empty flag shows no data left to send
// - Sending threshold byte sets near-empty and interrupt
// - Near-empty clears when writes pass threshold
// - Full flag set when full, writes ignored
// - Underrun during frame sends abort character
// - Threshold one to sixty-three, zero disables
// - Transmit FIFO holds sixty-four bytes
package tdl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_EOM  = 8'hAC;
  localparam logic [7:0] ADDR_DATA = 8'hAD;
  localparam logic [7:0] ADDR_STAT = 8'hAE;

  localparam int STAT_FULL_BIT  = 0;
  localparam int STAT_NEAR_BIT  = 1;
  localparam int STAT_EMPTY_BIT = 2;
  localparam int STAT_MSG_BIT   = 3;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // FIFO geometry
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 64;
  localparam int IDX_W      = 6;
  localparam int PTR_W      = 7;
  localparam logic [PTR_W-1:0] FIFO_FULL_LVL = 7'h40;
  localparam logic [PTR_W-1:0] PTR_ONE       = 7'h01;

  // ----------------------------------------------------------------
  // Modes and characters
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_FCS   = 2'h0;
  localparam logic [1:0] MODE_NOFCS = 2'h1;
  localparam logic [1:0] MODE_EIGHT_BIT_PACKED_MODE = 2'h2;
  localparam logic [1:0] MODE_SIX_BIT_PACKED_MODE = 2'h3;

  localparam logic [7:0]  FLAG_CHAR  = 8'h7E;
  localparam logic [7:0]  ABORT_CHAR = 8'hFF;
  localparam logic [7:0]  FILL_CHAR  = 8'hFF;
  localparam logic [15:0] CRC_INIT   = 16'hFFFF;
  localparam logic [15:0] CRC_POLY   = 16'h8408;
  localparam logic [3:0]  BITS_EIGHT = 4'h8;
  localparam logic [3:0]  BITS_SIX   = 4'h6;
  localparam logic [3:0]  BITS_ONE   = 4'h1;
  localparam logic [2:0]  STUFF_RUN  = 3'h5;

  typedef enum logic [4:0]
  {
    ST_IDLE   = 5'h01,
    ST_DATA   = 5'h02,
    ST_FCS_LO = 5'h04,
    ST_FCS_HI = 5'h08,
    ST_CLOSE  = 5'h10
  } tdl_state_e;

endpackage

// ### src/tdl_tx.sv
// Transmit data link: processor FIFO port, status and bit serializer.
// Assumes bit_tick pulses once per selected time-slot bit, on ref_clk.
`timescale 1ns/1ps
module tdl_tx
  import tdl_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] cpu_addr,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  input  wire logic       tx_enable,
  input  wire logic [1:0] link_mode,
  input  wire logic       circular_enable,
  input  wire logic [5:0] near_empty_threshold,
  input  wire logic       bit_tick,
  output logic            tx_bit,
  output logic            near_empty_interrupt,
  output logic            message_sent_interrupt
);

  typedef struct packed
  {
    logic [PTR_W-1:0] head;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] cur;
    logic [PTR_W-1:0] eom_cnt;
    tdl_state_e       st;
    logic [7:0]       sh;
    logic [3:0]       bits;
    logic             stuff;
    logic [2:0]       ones;
    logic [15:0]      crc;
    logic             msg;
    logic             near;
    logic             armed;
    logic             tx_bit;
    logic             near_irq;
    logic             msg_irq;
    logic [7:0]       rdata;
  } tdl_tx_s;

  tdl_tx_s q;
  tdl_tx_s d;

  logic [7:0]       buf_data;
  logic             buf_tag;
  logic             last_tag;
  logic [PTR_W-1:0] level;
  logic [PTR_W-1:0] new_level;
  logic             full;
  logic             empty;
  logic             wr_ok;
  logic             eom_ok;
  logic             packed_mode;
  logic [7:0]       sym;
  logic [3:0]       nb;
  logic             stf;
  logic             pop;
  logic             dec;
  logic             set_near;
  logic             out_b;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      fb = r[0] ^ b[i];
      r  = r >> 1;
      if (fb)
      begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

  assign level       = q.wptr - q.head;
  assign full        = (level == FIFO_FULL_LVL);
  assign empty       = (level == '0);
  assign wr_ok       = cpu_wr && (cpu_addr == ADDR_DATA) && !full;
  assign packed_mode = link_mode[1];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  tdl_buf #(
    .DATA_W (8),
    .DEPTH  (FIFO_DEPTH),
    .AW     (IDX_W)
  ) u_buf (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .wr_en    (wr_ok),
    .wr_idx   (q.wptr[IDX_W-1:0]),
    .wr_data  (cpu_wdata),
    .tag_set  (eom_ok),
    .tag_idx  (q.wptr[IDX_W-1:0] - 6'h01),
    .rd_idx   (q.cur[IDX_W-1:0]),
    .rd_data  (buf_data),
    .rd_tag   (buf_tag),
    .last_tag (last_tag)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d          = q;
    d.near_irq = 1'b0;
    d.msg_irq  = 1'b0;
    sym        = FILL_CHAR;
    nb         = BITS_EIGHT;
    stf        = 1'b0;
    pop        = 1'b0;
    dec        = 1'b0;
    set_near   = 1'b0;
    out_b      = 1'b1;
    eom_ok     = 1'b0;
    new_level  = level;

    if (bit_tick)
    begin
      if (q.stuff && (q.ones == STUFF_RUN))
      begin
        out_b  = 1'b0;
        d.ones = '0;
      end
      else if (q.bits != '0)
      begin
        out_b  = q.sh[0];
        d.sh   = q.sh >> 1;
        d.bits = q.bits - BITS_ONE;
        d.ones = (q.stuff && q.sh[0]) ? q.ones + 3'h1 : '0;
      end
      else
      begin
        if (!tx_enable)
        begin
          // Single idle ones keep the next enable aligned to a byte start
          nb    = BITS_ONE;
          d.st  = ST_IDLE;
          d.msg = packed_mode;
        end
        else if (packed_mode)
        begin
          d.msg = 1'b1;
          nb    = (link_mode == MODE_SIX_BIT_PACKED_MODE) ? BITS_SIX : BITS_EIGHT;
          if (circular_enable && (q.eom_cnt != '0))
          begin
            sym = buf_data;
            if (!buf_tag)
            begin
              d.cur = q.cur + PTR_ONE;
            end
            else if (q.eom_cnt > PTR_ONE)
            begin
              d.head    = q.cur + PTR_ONE;
              d.cur     = q.cur + PTR_ONE;
              dec       = 1'b1;
              d.msg_irq = 1'b1;
            end
            else
            begin
              d.cur = q.head;
            end
          end
          else if (!circular_enable && !empty)
          begin
            sym = buf_data;
            pop = 1'b1;
            if (buf_tag)
            begin
              dec       = 1'b1;
              d.msg_irq = 1'b1;
            end
          end
        end
        else
        begin
          case (q.st)
            ST_IDLE:
            begin
              sym = FLAG_CHAR;
              if (!empty)
              begin
                d.st  = ST_DATA;
                d.msg = 1'b1;
                d.crc = CRC_INIT;
              end
            end
            ST_DATA:
            begin
              if (empty)
              begin
                sym   = ABORT_CHAR;
                d.st  = ST_IDLE;
                d.msg = 1'b0;
              end
              else
              begin
                sym   = buf_data;
                stf   = 1'b1;
                pop   = 1'b1;
                d.crc = crc_byte(q.crc, buf_data);
                if (buf_tag)
                begin
                  dec  = 1'b1;
                  d.st = (link_mode == MODE_FCS) ? ST_FCS_LO : ST_CLOSE;
                end
              end
            end
            ST_FCS_LO:
            begin
              sym  = ~q.crc[7:0];
              stf  = 1'b1;
              d.st = ST_FCS_HI;
            end
            ST_FCS_HI:
            begin
              sym  = ~q.crc[15:8];
              stf  = 1'b1;
              d.st = ST_CLOSE;
            end
            ST_CLOSE:
            begin
              sym       = FLAG_CHAR;
              d.st      = ST_IDLE;
              d.msg     = 1'b0;
              d.msg_irq = 1'b1;
            end
            default:
            begin
              d.st  = ST_IDLE;
              d.msg = 1'b0;
            end
          endcase
        end
        out_b   = sym[0];
        d.sh    = sym >> 1;
        d.bits  = nb - BITS_ONE;
        d.stuff = stf;
        // The ones run carries across byte boundaries inside a frame
        d.ones  = (stf && sym[0]) ?
                  ((q.stuff ? q.ones : 3'h0) + 3'h1) : 3'h0;
      end
      d.tx_bit = out_b;
    end

    // Consume one byte and keep the read index on the head
    if (pop)
    begin
      d.head = q.head + PTR_ONE;
      d.cur  = q.head + PTR_ONE;
      if ((near_empty_threshold != '0) && q.armed &&
          (level == {1'b0, near_empty_threshold}))
      begin
        set_near   = 1'b1;
        d.near     = 1'b1;
        d.armed    = 1'b0;
        d.near_irq = 1'b1;
      end
    end

    if (wr_ok)
    begin
      d.wptr = q.wptr + PTR_ONE;
    end
    new_level = d.wptr - d.head;

    // Tag only a byte that is still queued and not yet tagged
    if (cpu_wr && (cpu_addr == ADDR_EOM) && (new_level != '0) && !last_tag)
    begin
      eom_ok = 1'b1;
    end
    d.eom_cnt = q.eom_cnt + {6'h00, eom_ok} - {6'h00, dec};

    // A set in the same cycle wins over the clear
    if (wr_ok && !set_near &&
        (new_level > {1'b0, near_empty_threshold}))
    begin
      d.near  = 1'b0;
      d.armed = 1'b1;
    end

    if (cpu_rd)
    begin
      d.rdata = RDATA_RST;
      if (cpu_addr == ADDR_STAT)
      begin
        d.rdata[STAT_MSG_BIT]   = q.msg || packed_mode;
        d.rdata[STAT_EMPTY_BIT] = empty;
        d.rdata[STAT_NEAR_BIT]  = q.near;
        d.rdata[STAT_FULL_BIT]  = full;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q       <= '0;
      q.st    <= ST_IDLE;
      q.armed <= 1'b1;
      q.tx_bit <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign cpu_rdata              = q.rdata;
  assign tx_bit                 = q.tx_bit;
  assign near_empty_interrupt   = q.near_irq;
  assign message_sent_interrupt = q.msg_irq;

endmodule

// ### tb/tb_top.sv
// Self-checking bench for the data link transmitter.
// Assumes the host model drives the port and the bench makes bit_tick.
`timescale 1ns/1ps
module tb_top
  import tdl_pkg::*;
;
  logic       ref_clk, nrst, tx_enable, bit_tick, tick_q;
  logic [1:0] link_mode;
  logic [5:0] th;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, rv;
  logic       cpu_wr, cpu_rd, tx_bit, ne_irq, ms_irq;
  logic [31:0] tick_s, dat_s;
  logic [7:0] exp_q [$];
  logic       rx_q [$];
  int         num_errors, n_tests, cyc, ne_cnt, ms_cnt, mx;

  tdl_host host (.ref_clk(ref_clk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));
  tdl_tx dut (.ref_clk(ref_clk), .nrst(nrst), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .tx_enable(tx_enable), .link_mode(link_mode),
    .circular_enable(1'b0), .near_empty_threshold(th),
    .bit_tick(bit_tick), .tx_bit(tx_bit), .near_empty_interrupt(ne_irq),
    .message_sent_interrupt(ms_irq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_b(input logic [7:0] b, input int w);
    return (w == 6) ? {2'b00, b[5:0]} : b;
  endfunction

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Tick source, serial capture, event counts, timeout
  // ----------------------------------------------------------------
  always @(negedge ref_clk)
  begin
    if (tick_q) rx_q.push_back(tx_bit);
    tick_s = lfsr(tick_s);
    bit_tick = tick_s[0];
  end
  always @(posedge ref_clk)
  begin
    tick_q <= bit_tick && tx_enable;
    cyc++;
    if (ne_irq) ne_cnt++;
    if (ms_irq) ms_cnt++;
    if (cyc == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic stat(input logic [7:0] m, input logic [7:0] e);
    host.rd(ADDR_STAT, rv);
    chk("status", e, rv & m);
  endtask
  task automatic drain(input int w, input int n);
    int k;
    logic [7:0] g;
    rx_q.delete();
    tx_enable = 1'b1;
    for (k = 0; k < 4000 && rx_q.size() < w * (n + 1); k++)
      @(negedge ref_clk);
    tx_enable = 1'b0;
    for (k = 0; k <= n; k++)
    begin
      g = 8'h00;
      for (int j = 0; j < w; j++) g[j] = rx_q.pop_front();
      chk("serial byte", exp_b(k < n ? exp_q.pop_front() : 8'hFF, w), g);
    end
  endtask
  task automatic hdlc_run(input int want, input int tail);
    int k, run;
    rx_q.delete();
    ms_cnt = 0;
    tx_enable = 1'b1;
    for (k = 0; k < 3000 && ms_cnt < want; k++)
    begin
      @(negedge ref_clk);
      if (k == 30) stat(8'h08, 8'h08);
    end
    repeat (tail) @(negedge ref_clk);
    tx_enable = 1'b0;
    run = 0;
    mx = 0;
    foreach (rx_q[i])
    begin
      run = (rx_q[i] === 1'b1) ? run + 1 : 0;
      if (run > mx) mx = run;
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    tx_enable = 1'b0;
    link_mode = MODE_FCS;
    th = 6'h05;
    tick_s = 32'h0883;
    dat_s = 32'h0883;
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    stat(8'hFF, 8'h04);
    host.wr(ADDR_EOM, 8'hA5);
    for (int i = 0; i < 3; i++)
    begin
      host.rd((i == 0) ? ADDR_EOM : ((i == 1) ? ADDR_DATA : 8'h3C), rv);
      chk("write-only read", 8'h00, rv);
    end
    $display("test registers done");
    link_mode = MODE_EIGHT_BIT_PACKED_MODE;
    for (int i = 0; i < 65; i++)
    begin
      dat_s = lfsr(dat_s);
      host.wr(ADDR_DATA, i < 64 ? dat_s[7:0] : 8'h00);
      if (i < 64) exp_q.push_back(dat_s[7:0]);
      if (i == 62) stat(8'h01, 8'h00);
    end
    stat(8'h0D, 8'h09);
    ne_cnt = 0;
    drain(8, 64);
    chk("near events", 8'h01, 8'(ne_cnt));
    stat(8'h07, 8'h06);
    $display("test fill and drain done");
    for (int i = 0; i <= 5; i++)
    begin
      dat_s = lfsr(dat_s);
      host.wr(ADDR_DATA, dat_s[7:0]);
      exp_q.push_back(dat_s[7:0]);
      stat(8'h02, i < 5 ? 8'h02 : 8'h00);
    end
    link_mode = MODE_SIX_BIT_PACKED_MODE;
    th = 6'h00;
    ne_cnt = 0;
    drain(6, 6);
    chk("near disabled", 8'h00, 8'(ne_cnt));
    $display("test six-bit done");
    link_mode = MODE_NOFCS;
    th = 6'h05;
    host.frame({8'h3C, 8'hA7, 8'hF0});
    host.frame({8'h81, 8'h1F, 8'h66});
    hdlc_run(2, 60);
    chk("frames sent", 8'h02, 8'(ms_cnt));
    chk("abort seen", 8'h00, {7'h00, mx > 6});
    stat(8'h0C, 8'h04);
    for (int i = 0; i < 3; i++) host.wr(ADDR_DATA, 8'h00);
    hdlc_run(0, 300);
    chk("abort seen", 8'h01, {7'h00, mx > 6});
    $display("test hdlc done");
    print_verdict();
  end
endmodule

// ### tb/tdl_host.sv
// Host processor model on the byte-wide register port.
// Assumes ref_clk from the bench; changes signals on the falling edge.
`timescale 1ns/1ps
module tdl_host
  import tdl_pkg::*;
(
  input  wire logic       ref_clk,
  output logic      [7:0] cpu_addr,
  output logic            cpu_wr,
  output logic            cpu_rd,
  output logic      [7:0] cpu_wdata,
  input  wire logic [7:0] cpu_rdata
);
  initial
  begin
    cpu_addr = 8'h00;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge ref_clk);
    cpu_wr = 1'b0;
    // Released data bus shows the inverse, not the stale byte
    cpu_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge ref_clk);
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask

  task automatic frame(input logic [7:0] b [$]);
    foreach (b[i]) wr(ADDR_DATA, b[i]);
    wr(ADDR_EOM, 8'h5A);
  endtask
endmodule

// ### tb/tdl_tx_properties.sv
// Concurrent checks on the ports of the data link transmitter.
// Assumes the single ref_clk domain and asynchronous active-low nrst.
`timescale 1ns/1ps
module tdl_tx_properties
  import tdl_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [7:0] cpu_addr,
  input wire logic       cpu_wr,
  input wire logic       cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic       tx_enable,
  input wire logic [1:0] link_mode,
  input wire logic       circular_enable,
  input wire logic [5:0] near_empty_threshold,
  input wire logic       bit_tick,
  input wire logic       tx_bit,
  input wire logic       near_empty_interrupt,
  input wire logic       message_sent_interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  chk_wo_read_zero: assert property (
    cpu_rd && (cpu_addr == ADDR_EOM || cpu_addr == ADDR_DATA)
    |=> cpu_rdata == 8'h00) else $error("write-only place read nonzero");
  chk_stat_sane: assert property (
    cpu_rd && cpu_addr == ADDR_STAT |=> cpu_rdata[7:4] == 4'h0 &&
    !(cpu_rdata[STAT_FULL_BIT] && cpu_rdata[STAT_EMPTY_BIT]))
    else $error("status has spare bits or full with empty");
  chk_msg_packed: assert property (
    cpu_rd && cpu_addr == ADDR_STAT && link_mode[1]
    |=> cpu_rdata[STAT_MSG_BIT]) else $error("in-progress low in packed");

  // ----------------------------------------------------------------
  // Serial side and events
  // ----------------------------------------------------------------
  chk_bit_hold: assert property (
    !bit_tick && tx_enable |=> $stable(tx_bit) || !tx_enable)
    else $error("serial bit moved without a tick");
  chk_ne_pulse: assert property (
    near_empty_interrupt |=> !near_empty_interrupt)
    else $error("near-empty interrupt held");
  chk_ms_pulse: assert property (
    message_sent_interrupt |=> !message_sent_interrupt)
    else $error("message interrupt held");
  chk_ne_disabled: assert property (
    near_empty_interrupt |-> $past(near_empty_threshold) != 6'h00)
    else $error("near-empty interrupt with zero threshold");
  chk_ne_on_tick: assert property (
    near_empty_interrupt |-> $past(bit_tick) || $past(bit_tick, 2))
    else $error("near-empty interrupt without a pop");
  chk_ms_on_tick: assert property (
    message_sent_interrupt |-> $past(bit_tick) || $past(bit_tick, 2))
    else $error("message interrupt without a tick");

  cov_near: cover property (near_empty_interrupt);
  cov_msg: cover property (message_sent_interrupt);
  cov_fill: cover property (cpu_wr && cpu_addr == ADDR_DATA);
endmodule

bind tdl_tx tdl_tx_properties u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
  .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
  .tx_enable(tx_enable), .link_mode(link_mode),
  .circular_enable(circular_enable),
  .near_empty_threshold(near_empty_threshold), .bit_tick(bit_tick),
  .tx_bit(tx_bit), .near_empty_interrupt(near_empty_interrupt),
  .message_sent_interrupt(message_sent_interrupt));
